/* File: logic/sdr_regs.sv */
// Configuration register bank: divider, doubler, calibration seed and ramp limits
//
// Chosen here: the Wishbone register port.
module sdr_regs (
    input  wire logic        clk,                  // 250 MHz clock
    input  wire logic        resetn,               // Synchronous reset, active low
    input  wire logic        wb_cyc_i,             // Wishbone cycle
    input  wire logic        wb_stb_i,             // Wishbone strobe
    input  wire logic        wb_we_i,              // Wishbone write enable
    input  wire logic [8:0]  wb_adr_i,             // Wishbone byte address
    input  wire logic [3:0]  wb_sel_i,             // Wishbone byte lanes
    input  wire logic [31:0] wb_dat_i,             // Wishbone write data
    output logic      [31:0] wb_dat_o,             // Wishbone read data
    output logic             wb_ack_o,             // Wishbone acknowledge
    input  wire logic [1:0]  last_core_i,          // Core found by last calibration
    input  wire logic [7:0]  last_cap_band_i,      // Cap band found by last calibration
    input  wire logic [8:0]  last_dac_current_i,   // DAC current found by last calibration
    output logic             freq_doubler_on,      // Doubler enabled
    output logic      [15:0] doubler_bias_setting, // Bias to the doubler only
    output logic             divider_buffer_on,    // Extra divider buffer enable
    output logic      [4:0]  output_divide_ratio,  // Divider code
    output logic      [9:0]  divide_value,         // Decoded ratio
    output logic             divide_by_two_path,   // Ratio equals two
    output logic             fast_recalibration,   // Fast recalibration enabled
    output logic             seed_from_last,       // Seeds below come from last result
    output logic      [1:0]  oscillator_core_select, // Calibration core seed
    output logic      [7:0]  cap_band_select,      // Calibration cap band seed
    output logic      [8:0]  oscillator_dac_current, // Calibration DAC seed
    output logic             ramp_active,          // Ramp engine enabled
    output logic      [32:0] recal_step_threshold, // Threshold seen by ramp engine
    output logic      [32:0] ramp_high_limit,      // Upper limit seen by ramp engine
    output logic      [32:0] ramp_low_limit        // Lower limit seen by ramp engine
);
    import sdr_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        ack;
        logic [15:0] rdata;
        logic        ramp_on;
        logic [15:0] bias;
        logic        dbl_on;
        logic        buf_on;
        logic [4:0]  div_code;
        logic [32:0] thr;
        logic        fast;
        logic [7:0]  cap;
        logic [32:0] hi;
        logic [32:0] lo;
        logic [9:0]  ratio;
        logic        ratio_ok;
        logic        seed_last;
        logic [1:0]  seed_core;
        logic [7:0]  seed_cap;
        logic [8:0]  seed_dac;
        logic [32:0] thr_out;
        logic [32:0] hi_out;
        logic [32:0] lo_out;
    } sdr_state_s;

    sdr_state_s st_r;
    sdr_state_s st_nxt;

    logic        req;
    logic [6:0]  idx;
    logic [15:0] old_word;
    logic [15:0] new_word;
    logic        buf_warn;

    logic [DIV_CODE_MAX:0] code_hit;
    logic [9:0]            ratio_hit [DIV_CODE_MAX:0];
    logic [9:0]            ratio_dec;

    // Merge write data into a word under the two low byte lanes
    function automatic logic [15:0] sdr_merge(input logic [15:0] old_v,
                                              input logic [15:0] wr_v,
                                              input logic [1:0]  sel_v);
        logic [15:0] res;
        res = old_v;
        if (sel_v[0]) begin
            res[7:0] = wr_v[7:0];
        end
        if (sel_v[1]) begin
            res[15:8] = wr_v[15:8];
        end
        return res;
    endfunction

    assign req      = wb_cyc_i && wb_stb_i && !st_r.ack;
    assign idx      = wb_adr_i[8:2];
    assign buf_warn = !st_r.buf_on && st_r.ratio_ok && (st_r.ratio != RATIO_TWO);

    // ------------------------------------------------------------------
    // Divider decode: one comparator per legal code, reserved codes hit none
    // ------------------------------------------------------------------
    for (genvar g = 0; g <= int'(DIV_CODE_MAX); g++) begin : g_div
        assign code_hit[g]  = (st_r.div_code == 5'(g));
        assign ratio_hit[g] = code_hit[g] ? DIV_RATIO[g] : 10'h000;
    end

    always_comb begin
        ratio_dec = 10'h000;
        for (int k = 0; k <= int'(DIV_CODE_MAX); k++) begin
            ratio_dec = ratio_dec | ratio_hit[k];
        end
    end

    // ------------------------------------------------------------------
    // Read view of every register
    // ------------------------------------------------------------------
    always_comb begin
        old_word = 16'h0000;
        case (idx)
            IDX_RAMP_CONTROL: old_word[RAMP_ON_BIT] = st_r.ramp_on;
            IDX_STATUS: begin
                old_word[ST_RATIO_OK_BIT] = st_r.ratio_ok;
                old_word[ST_BUF_WARN_BIT] = buf_warn;
                old_word[ST_RAMP_ACT_BIT] = st_r.ramp_on;
            end
            IDX_DBL_BIAS:  old_word = st_r.bias;
            IDX_DBL_EN:    old_word = DBL_EN_FIXED | {15'h0000, st_r.dbl_on};
            IDX_DIV_BUF: begin
                old_word = DIV_BUF_FIXED;
                old_word[BUF_ON_BIT] = st_r.buf_on;
            end
            IDX_OUT_DIV: begin
                old_word = OUT_DIV_FIXED;
                old_word[DIV_MSB:DIV_LSB] = st_r.div_code;
            end
            IDX_CAL_START: begin
                old_word = CAL_START_FIXED;
                old_word[THR_TOP_BIT] = st_r.thr[32];
                old_word[FAST_RECAL_BIT] = st_r.fast;
                old_word[CAP_MSB:CAP_LSB] = st_r.cap;
            end
            IDX_THR_UPPER: old_word = st_r.thr[31:16];
            IDX_THR_LOWER: old_word = st_r.thr[15:0];
            IDX_HI_TOP:    old_word[LIMIT_TOP_BIT] = st_r.hi[32];
            IDX_HI_UPPER:  old_word = st_r.hi[31:16];
            IDX_HI_LOWER:  old_word = st_r.hi[15:0];
            IDX_LO_TOP:    old_word[LIMIT_TOP_BIT] = st_r.lo[32];
            IDX_LO_UPPER:  old_word = st_r.lo[31:16];
            IDX_LO_LOWER:  old_word = st_r.lo[15:0];
            default:       old_word = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt     = st_r;
        new_word   = sdr_merge(old_word, wb_dat_i[15:0], wb_sel_i[1:0]);
        st_nxt.ack = req;
        if (req && !wb_we_i) begin
            st_nxt.rdata = old_word;
        end
        if (req && wb_we_i) begin
            // Fixed bits are rebuilt on read, so written values there are dropped
            case (idx)
                IDX_RAMP_CONTROL: st_nxt.ramp_on = new_word[RAMP_ON_BIT];
                IDX_DBL_BIAS:  st_nxt.bias = new_word;
                IDX_DBL_EN:    st_nxt.dbl_on = new_word[DBL_ON_BIT];
                IDX_DIV_BUF:   st_nxt.buf_on = new_word[BUF_ON_BIT];
                IDX_OUT_DIV:   st_nxt.div_code = new_word[DIV_MSB:DIV_LSB];
                IDX_CAL_START: begin
                    st_nxt.thr[32] = new_word[THR_TOP_BIT];
                    st_nxt.fast    = new_word[FAST_RECAL_BIT];
                    st_nxt.cap     = new_word[CAP_MSB:CAP_LSB];
                end
                IDX_THR_UPPER: st_nxt.thr[31:16] = new_word;
                IDX_THR_LOWER: st_nxt.thr[15:0]  = new_word;
                IDX_HI_TOP:    st_nxt.hi[32]     = new_word[LIMIT_TOP_BIT];
                IDX_HI_UPPER:  st_nxt.hi[31:16]  = new_word;
                IDX_HI_LOWER:  st_nxt.hi[15:0]   = new_word;
                IDX_LO_TOP:    st_nxt.lo[32]     = new_word[LIMIT_TOP_BIT];
                IDX_LO_UPPER:  st_nxt.lo[31:16]  = new_word;
                IDX_LO_LOWER:  st_nxt.lo[15:0]   = new_word;
                default: begin
                end
            endcase
        end

        // Divider decode; reserved codes hold the last valid ratio
        st_nxt.ratio_ok = (st_r.div_code <= DIV_CODE_MAX);
        if (st_r.div_code <= DIV_CODE_MAX) begin
            st_nxt.ratio = ratio_dec;
        end

        // Calibration seed selection
        st_nxt.seed_last = st_r.fast;
        if (st_r.fast) begin
            st_nxt.seed_core = last_core_i;
            st_nxt.seed_cap  = last_cap_band_i;
            st_nxt.seed_dac  = last_dac_current_i;
        end else begin
            st_nxt.seed_core = 2'h0;
            st_nxt.seed_dac  = 9'h000;
            // Out-of-range start values are clamped to the top band code
            st_nxt.seed_cap  = (st_r.cap > CAP_START_MAX) ? CAP_START_MAX : st_r.cap;
        end

        // Ramp settings reach the ramp engine only while ramping is on
        if (st_r.ramp_on) begin
            st_nxt.thr_out = st_r.thr;
            st_nxt.hi_out  = st_r.hi;
            st_nxt.lo_out  = st_r.lo;
        end else begin
            st_nxt.thr_out = THR_RST;
            st_nxt.hi_out  = LIMIT_RST;
            st_nxt.lo_out  = LIMIT_RST;
        end

        if (!resetn) begin
            st_nxt           = '0;
            st_nxt.bias      = DBL_BIAS_RST;
            st_nxt.dbl_on    = 1'b0;
            st_nxt.div_code  = DIV_CODE_RST;
            st_nxt.cap       = CAP_START_RST;
            st_nxt.thr       = THR_RST;
            st_nxt.hi        = LIMIT_RST;
            st_nxt.lo        = LIMIT_RST;
            st_nxt.ratio     = RATIO_TWO;
            st_nxt.ratio_ok  = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign wb_ack_o               = st_r.ack;
    assign wb_dat_o               = {16'h0000, st_r.rdata};
    assign freq_doubler_on        = st_r.dbl_on;
    assign doubler_bias_setting   = st_r.bias;
    assign divider_buffer_on      = st_r.buf_on;
    assign output_divide_ratio    = st_r.div_code;
    assign divide_value           = st_r.ratio;
    assign divide_by_two_path     = (st_r.ratio == RATIO_TWO);
    assign fast_recalibration     = st_r.fast;
    assign seed_from_last         = st_r.seed_last;
    assign oscillator_core_select = st_r.seed_core;
    assign cap_band_select        = st_r.seed_cap;
    assign oscillator_dac_current = st_r.seed_dac;
    assign ramp_active            = st_r.ramp_on;
    assign recal_step_threshold   = st_r.thr_out;
    assign ramp_high_limit        = st_r.hi_out;
    assign ramp_low_limit         = st_r.lo_out;
endmodule // sdr_regs

/* File: pkg/sdr_pkg.sv */
// Package of offsets, field layouts and reset values for the synthesizer config bank
package sdr_pkg;
    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [6:0] IDX_RAMP_CONTROL   = 7'h00;
    localparam logic [6:0] IDX_STATUS         = 7'h01;
    localparam logic [6:0] IDX_DBL_BIAS       = 7'h19;
    localparam logic [6:0] IDX_DBL_EN         = 7'h1b;
    localparam logic [6:0] IDX_DIV_BUF        = 7'h1f;
    localparam logic [6:0] IDX_OUT_DIV        = 7'h4b;
    localparam logic [6:0] IDX_CAL_START      = 7'h4e;
    localparam logic [6:0] IDX_THR_UPPER      = 7'h4f;
    localparam logic [6:0] IDX_THR_LOWER      = 7'h50;
    localparam logic [6:0] IDX_HI_TOP         = 7'h51;
    localparam logic [6:0] IDX_HI_UPPER       = 7'h52;
    localparam logic [6:0] IDX_HI_LOWER       = 7'h53;
    localparam logic [6:0] IDX_LO_TOP         = 7'h54;
    localparam logic [6:0] IDX_LO_UPPER       = 7'h55;
    localparam logic [6:0] IDX_LO_LOWER       = 7'h56;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int RAMP_ON_BIT      = 15;
    localparam int DBL_ON_BIT       = 0;
    localparam int BUF_ON_BIT       = 14;
    localparam int DIV_LSB          = 6;
    localparam int DIV_MSB          = 10;
    localparam int THR_TOP_BIT      = 11;
    localparam int FAST_RECAL_BIT   = 9;
    localparam int CAP_LSB          = 1;
    localparam int CAP_MSB          = 8;
    localparam int LIMIT_TOP_BIT    = 0;
    localparam int ST_RATIO_OK_BIT  = 0;
    localparam int ST_BUF_WARN_BIT  = 1;
    localparam int ST_RAMP_ACT_BIT  = 2;

    // ------------------------------------------------------------------
    // Reset values and fixed bit patterns
    // ------------------------------------------------------------------
    localparam logic [15:0] DBL_BIAS_RST    = 16'h0624;
    localparam logic [15:0] DBL_BIAS_ALT    = 16'h0c2b;
    localparam logic [15:0] DBL_EN_FIXED    = 16'h0002;
    localparam logic [15:0] DIV_BUF_FIXED   = 16'h03ec;
    localparam logic [15:0] OUT_DIV_FIXED   = 16'h0800;
    localparam logic [15:0] CAL_START_FIXED = 16'h0001;
    localparam logic [32:0] LIMIT_RST       = 33'h0_0000_0000;
    localparam logic [32:0] THR_RST         = 33'h0_0000_0000;
    localparam logic [4:0]  DIV_CODE_RST    = 5'h00;
    localparam logic [4:0]  DIV_CODE_MAX    = 5'h11;
    localparam logic [7:0]  CAP_START_RST   = 8'h00;
    localparam logic [7:0]  CAP_START_MAX   = 8'hb7;
    localparam logic [9:0]  RATIO_TWO       = 10'h002;

    // Output divide ratio for codes 0 to 17
    localparam logic [9:0] DIV_RATIO [18] = '{
        10'h002, 10'h004, 10'h006, 10'h008, 10'h00c, 10'h010,
        10'h018, 10'h020, 10'h030, 10'h040, 10'h048, 10'h060,
        10'h080, 10'h0c0, 10'h100, 10'h180, 10'h200, 10'h300};
endpackage

/* File: verif/sdr_regs_checker.sv */
// Assertion checker for the synthesizer configuration register bank
module sdr_regs_checker
    import sdr_pkg::*;
(
    input wire logic        clk,                    // Clock
    input wire logic        resetn,                 // Reset, active low
    input wire logic        wb_cyc_i,               // Cycle
    input wire logic        wb_stb_i,               // Strobe
    input wire logic [31:0] wb_dat_o,               // Read data
    input wire logic        wb_ack_o,               // Acknowledge
    input wire logic [7:0]  last_cap_band_i,        // Last cap band
    input wire logic        freq_doubler_on,        // Doubler on
    input wire logic [15:0] doubler_bias_setting,   // Doubler bias
    input wire logic [4:0]  output_divide_ratio,    // Divider code
    input wire logic [9:0]  divide_value,           // Decoded ratio
    input wire logic        divide_by_two_path,     // Ratio is two
    input wire logic        fast_recalibration,     // Fast recal
    input wire logic        seed_from_last,         // Seeds from last result
    input wire logic [1:0]  oscillator_core_select, // Core seed
    input wire logic [7:0]  cap_band_select,        // Cap seed
    input wire logic [8:0]  oscillator_dac_current, // DAC seed
    input wire logic        ramp_active,            // Ramp on
    input wire logic [32:0] recal_step_threshold,   // Threshold
    input wire logic [32:0] ramp_high_limit,        // Upper limit
    input wire logic [32:0] ramp_low_limit          // Lower limit
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged in the next cycle");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_reset_values: assert property ($rose(resetn) |-> doubler_bias_setting == 16'h0624 && !freq_doubler_on)
        else $error("bias or doubler wrong after reset");
    a_ratio_decode: assert property ($stable(output_divide_ratio) && output_divide_ratio <= 5'h11 |-> divide_value == DIV_RATIO[output_divide_ratio])
        else $error("divide ratio does not match code");
    a_two_path: assert property ($stable(output_divide_ratio)
        && output_divide_ratio <= 5'h11 |-> divide_by_two_path == (output_divide_ratio == 5'h00))
        else $error("divide by two flag wrong");
    a_ramp_gated: assert property (!ramp_active |=> recal_step_threshold == 33'h0 && ramp_high_limit == 33'h0 && ramp_low_limit == 33'h0)
        else $error("ramp values seen while ramp off");
    a_seed_last: assert property (seed_from_last && $past(seed_from_last) && $stable(last_cap_band_i) |-> cap_band_select == last_cap_band_i)
        else $error("fast seed not taken from last result");
    a_seed_default: assert property (!seed_from_last && !$past(seed_from_last) && !$past(fast_recalibration) |-> oscillator_core_select == 2'h0 && oscillator_dac_current == 9'h000 && cap_band_select <= 8'hb7)
        else $error("default seed wrong");

    c_read_ack: cover property (wb_ack_o);
    c_fast_seed: cover property (seed_from_last);
    c_ramp_on: cover property (ramp_active);
    c_top_code: cover property (output_divide_ratio == 5'h11);
endmodule // sdr_regs_checker

bind sdr_regs sdr_regs_checker u_chk (.clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
    .last_cap_band_i, .freq_doubler_on, .doubler_bias_setting, .output_divide_ratio,
    .divide_value, .divide_by_two_path, .fast_recalibration, .seed_from_last,
    .oscillator_core_select, .cap_band_select, .oscillator_dac_current, .ramp_active,
    .recal_step_threshold, .ramp_high_limit, .ramp_low_limit);

/* File: verif/tb_top.sv */
// Self-checking testbench for the synthesizer configuration register bank
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sdr_pkg::*;
    logic        clk = 0, resetn = 0, req = 0, we = 0;
    logic [8:0]  adr = '0, ldac = '0, dac;
    logic [31:0] wdat = '0, rdat;
    logic [1:0]  lcore = '0, core;
    logic [7:0]  lcap = '0, cap;
    logic        ack, dbl, bufon, two, fast, sfl, ramp;
    logic [15:0] bias;
    logic [4:0]  code;
    logic [9:0]  dval;
    logic [32:0] thr, hi, lo;
    logic [31:0] exp_q[$];
    int fail_count = 0, num_checks = 0, cyc_n = 0;
    int rat[18] = '{2, 4, 6, 8, 12, 16, 24, 32, 48, 64, 72, 96, 128, 192, 256, 384, 512, 768};

    always #2 clk = ~clk;

    sdr_regs dut (.clk(clk), .resetn(resetn), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .last_core_i(lcore), .last_cap_band_i(lcap), .last_dac_current_i(ldac),
        .freq_doubler_on(dbl), .doubler_bias_setting(bias), .divider_buffer_on(bufon),
        .output_divide_ratio(code), .divide_value(dval), .divide_by_two_path(two),
        .fast_recalibration(fast), .seed_from_last(sfl), .oscillator_core_select(core),
        .cap_band_select(cap), .oscillator_dac_current(dac), .ramp_active(ramp),
        .recal_step_threshold(thr), .ramp_high_limit(hi), .ramp_low_limit(lo));

    // ------
    // Tasks
    // ------
    task automatic chk(string n, logic [32:0] e, logic [32:0] s);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(logic [6:0] i, logic w, logic [15:0] d);
        @(posedge clk);
        req  <= 1'b1;
        we   <= w;
        adr  <= {i, 2'b00};
        wdat <= {16'h0000, d};
        do @(posedge clk); while (ack !== 1'b1);
        req <= 1'b0;
    endtask
    task automatic wr(logic [6:0] i, logic [15:0] d);
        bus(i, 1'b1, d);
    endtask
    task automatic rd(logic [6:0] i, logic [15:0] e);
        exp_q.push_back({16'h0000, e});
        bus(i, 1'b0, 16'h0000);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Read monitor and timeout
    always @(posedge clk) begin
        cyc_n++;
        if (ack === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0) chk("unexpected read", 33'h1, 33'h0);
            else chk("read data", exp_q.pop_front(), rdat);
        end
        if (cyc_n == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    // ---------
    // Scenarios
    // ---------
    initial begin
        int r;
        logic [31:0] v;
        logic [7:0] s;
        r = $urandom(3);
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        rd(IDX_DBL_BIAS, 16'h0624);
        rd(IDX_DBL_EN, 16'h0002);
        rd(IDX_DIV_BUF, 16'h03ec);
        rd(IDX_OUT_DIV, 16'h0800);
        rd(IDX_CAL_START, 16'h0001);
        for (int i = 0; i < 8; i++) rd(7'(IDX_THR_UPPER + i), 16'h0000);
        chk("div reset", 33'd2, dval);
        wr(IDX_DBL_BIAS, 16'h0c2b);
        rd(IDX_DBL_BIAS, 16'h0c2b);
        chk("bias", 33'h0c2b, bias);
        chk("doubler kept off", 33'h0, dbl);
        wr(IDX_DBL_EN, 16'h0003);
        rd(IDX_DBL_EN, 16'h0003);
        chk("doubler on", 33'h1, dbl);
        wr(IDX_DBL_EN, 16'h0002);
        chk("doubler off", 33'h0, dbl);
        for (int c = 0; c < 20; c++) begin
            r = (c == 19) ? 31 : c;
            wr(IDX_DIV_BUF, {1'b0, r != 0 && r < 18, 14'h03ec});
            wr(IDX_OUT_DIV, 16'h0800 | 16'(r << 6));
            repeat (2) @(posedge clk);
            chk("code", r, code);
            chk("ratio", (r < 18) ? rat[r] : 768, dval);
            chk("div two", r == 0, two);
            chk("buffer", r != 0 && r < 18, bufon);
        end
        rd(IDX_OUT_DIV, 16'h0fc0);
        rd(IDX_STATUS, 16'h0000);
        wr(IDX_OUT_DIV, 16'h0840);
        rd(IDX_STATUS, 16'h0003);
        for (int k = 0; k < 3; k++) begin
            s = (k == 1) ? 8'hc8 : 8'($urandom_range(183));
            lcap  <= 8'($urandom);
            lcore <= 2'($urandom);
            ldac  <= 9'($urandom);
            wr(IDX_CAL_START, {6'h00, k == 2, s, 1'b1});
            repeat (3) @(posedge clk);
            rd(IDX_CAL_START, {6'h00, k == 2, s, 1'b1});
            chk("cap seed", (k == 2) ? lcap : (k == 1) ? 8'hb7 : s, cap);
            chk("core seed", (k == 2) ? lcore : 2'h0, core);
            chk("dac seed", (k == 2) ? ldac : 9'h000, dac);
            chk("fast bit", k == 2, fast);
            chk("seed flag", k == 2, sfl);
        end
        v = $urandom;
        wr(IDX_CAL_START, 16'h0801);
        wr(IDX_THR_UPPER, v[15:0]);
        wr(IDX_THR_LOWER, v[31:16]);
        wr(IDX_HI_TOP, 16'h0001);
        wr(IDX_HI_UPPER, v[31:16]);
        wr(IDX_HI_LOWER, v[15:0]);
        wr(IDX_LO_TOP, 16'h0001);
        wr(IDX_LO_UPPER, ~v[31:16]);
        wr(IDX_LO_LOWER, ~v[15:0]);
        for (int m = 0; m < 2; m++) begin
            repeat (2) @(posedge clk);
            chk("threshold", m ? {1'b1, v[15:0], v[31:16]} : 33'h0, thr);
            chk("high limit", m ? {1'b1, v} : 33'h0, hi);
            chk("low limit", m ? {1'b1, ~v} : 33'h0, lo);
            chk("ramp on", m, ramp);
            wr(IDX_RAMP_CONTROL, 16'h8000);
        end
        rd(IDX_LO_TOP, 16'h0001);
        rd(IDX_STATUS, 16'h0007);
        wr(IDX_STATUS, 16'h0000);
        rd(IDX_STATUS, 16'h0007);
        wr(7'h7f, 16'hffff);
        rd(7'h7f, 16'h0000);
        wr(IDX_RAMP_CONTROL, 16'h0000);
        repeat (2) @(posedge clk);
        chk("ramp off", 33'h0, hi);
        repeat (2) @(posedge clk);
        chk("reads pending", 33'h0, 33'(exp_q.size()));
        tally_and_finish();
    end
endmodule // tb_top
